// [pkg/cicd_regs.svh]
`ifndef CICD_REGS_SVH
`define CICD_REGS_SVH
// opcode rows (high nibble)
`define CICD_ROW_BITBR 4'h0
`define CICD_ROW_BITMAN 4'h1
`define CICD_ROW_BRANCH 4'h2
`define CICD_ROW_RMW_DIR 4'h3
`define CICD_ROW_RMW_A 4'h4
`define CICD_ROW_RMW_X 4'h5
`define CICD_ROW_RMW_IX1 4'h6
`define CICD_ROW_RMW_IX 4'h7
`define CICD_ROW_CTL_A 4'h8
`define CICD_ROW_CTL_B 4'h9
`define CICD_ROW_IMM 4'hA
`define CICD_ROW_DIR 4'hB
`define CICD_ROW_EXT 4'hC
`define CICD_ROW_IX2 4'hD
`define CICD_ROW_IX1 4'hE
`define CICD_ROW_IX 4'hF
// whole opcodes with special handling
`define CICD_OP_UMULT 8'h42
`define CICD_OP_TRAP_RET 8'h80
`define CICD_OP_RTS 8'h81
`define CICD_OP_TRAP 8'h83
`define CICD_OP_STOP 8'h8E
`define CICD_OP_WAIT 8'h8F
`define CICD_OP_A2X 8'h97
`define CICD_OP_CLC 8'h98
`define CICD_OP_SEC 8'h99
`define CICD_OP_CLI 8'h9A
`define CICD_OP_SEI 8'h9B
`define CICD_OP_SP_INIT 8'h9C
`define CICD_OP_NOP 8'h9D
`define CICD_OP_X2A 8'h9F
`define CICD_OP_BR_SUB 8'hAD
// read-modify-write low nibbles
`define CICD_RMW_NEG 4'h0
`define CICD_RMW_COM 4'h3
`define CICD_RMW_LSR 4'h4
`define CICD_RMW_ROR 4'h6
`define CICD_RMW_ASR 4'h7
`define CICD_RMW_ASL 4'h8
`define CICD_RMW_ROL 4'h9
`define CICD_RMW_DEC 4'hA
`define CICD_RMW_INC 4'hC
`define CICD_RMW_TEST 4'hD
`define CICD_RMW_CLR 4'hF
// register/memory low nibbles for jumps
`define CICD_RM_JUMP 4'hC
`define CICD_RM_JUMP_SUB 4'hD
// direct page high byte
`define CICD_DIRECT_PAGE 8'h00
// reset values
`define CICD_PC_RESET 16'h0000
`define CICD_BYTE_RESET 8'h00
`endif

// [pkg/cicd_pkg.sv]
package cicd_pkg;
    // instruction classes
    typedef enum logic [2:0] {
        CICD_CLS_REGMEM,
        CICD_CLS_RMW,
        CICD_CLS_JUMP,
        CICD_CLS_BITMAN,
        CICD_CLS_CONTROL,
        CICD_CLS_ILLEGAL
    } cicd_class_t;
    // addressing modes
    typedef enum logic [2:0] {
        CICD_MODE_INH,
        CICD_MODE_IMM,
        CICD_MODE_DIR,
        CICD_MODE_EXT,
        CICD_MODE_IX,
        CICD_MODE_IX1,
        CICD_MODE_IX2,
        CICD_MODE_REL
    } cicd_mode_t;
    // write-back destinations
    typedef enum logic [1:0] {
        CICD_WB_NONE,
        CICD_WB_MEM,
        CICD_WB_ACC,
        CICD_WB_IDX
    } cicd_wb_t;
    // condition code bits
    typedef struct packed {
        logic h;
        logic i;
        logic n;
        logic z;
        logic c;
    } cicd_ccr_t;
    // decoded instruction summary
    typedef struct packed {
        cicd_class_t cls;
        cicd_mode_t mode;
        logic [3:0] sel;
        logic use_idx;
        logic push_pc;
        logic pop_pc;
        logic sp_reset;
    } cicd_decode_t;
endpackage : cicd_pkg

// [core/cicd_core.sv]
`timescale 1ns/1ps
`include "cicd_regs.svh"

module cicd_core
    import cicd_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic reset_n_in,
    input wire logic op_valid_in,
    input wire logic [7:0] opcode_in,
    input wire logic [7:0] operand1_in,
    input wire logic [7:0] operand2_in,
    input wire logic [15:0] pc_next_in,
    input wire logic [7:0] acc_in,
    input wire logic [7:0] idx_in,
    input wire logic [7:0] mem_byte_in,
    input wire cicd_ccr_t ccr_in,
    input wire logic irq_pin_in,
    output cicd_decode_t decode_out,
    output logic done_out,
    output logic branch_taken_out,
    output logic [15:0] pc_target_out,
    output logic [15:0] ea_out,
    output logic wb_en_out,
    output cicd_wb_t wb_target_out,
    output logic [7:0] wb_data_out,
    output logic [7:0] acc_out,
    output logic [7:0] idx_out,
    output cicd_ccr_t ccr_out,
    output logic stop_req_out,
    output logic wait_req_out
);

    // relative destination, wraps at 16 bits
    function automatic logic [15:0] branch_dest(input logic [15:0] pc,
                                                input logic [7:0] off);
        branch_dest = 16'(pc + {{8{off[7]}}, off});
    endfunction : branch_dest

    // relative branch condition by low nibble
    function automatic logic branch_cond(input logic [3:0] sel,
                                         input cicd_ccr_t f,
                                         input logic pin);
        logic t;
        t = 1'b0;
        // even codes test the true sense, odd codes invert it
        unique case (sel[3:1])
            3'h0: t = 1'b1;
            3'h1: t = ~(f.c | f.z);
            3'h2: t = ~f.c;
            3'h3: t = ~f.z;
            3'h4: t = ~f.h;
            3'h5: t = ~f.n;
            3'h6: t = ~f.i;
            3'h7: t = ~pin;
        endcase
        branch_cond = t ^ sel[0];
    endfunction : branch_cond

    // rmw datapath: returns {carry, result}
    function automatic logic [8:0] rmw_calc(input logic [3:0] sel,
                                            input logic [7:0] v,
                                            input logic c);
        logic [8:0] r;
        r = {c, v};
        unique case (sel)
            `CICD_RMW_NEG: r = {v != 8'h00, 8'(8'h00 - v)};
            `CICD_RMW_COM: r = {1'b1, ~v};
            `CICD_RMW_LSR: r = {v[0], 1'b0, v[7:1]};
            `CICD_RMW_ROR: r = {v[0], c, v[7:1]};
            `CICD_RMW_ASR: r = {v[0], v[7], v[7:1]};
            `CICD_RMW_ASL: r = {v[7], v[6:0], 1'b0};
            `CICD_RMW_ROL: r = {v[7], v[6:0], c};
            `CICD_RMW_DEC: r = {c, 8'(v - 8'h01)};
            `CICD_RMW_INC: r = {c, 8'(v + 8'h01)};
            `CICD_RMW_TEST: r = {c, v};
            `CICD_RMW_CLR: r = {c, 8'h00};
            default: r = {c, v};
        endcase
        rmw_calc = r;
    endfunction : rmw_calc

    // decode, combinational
    cicd_decode_t next_decode; // decoded opcode
    logic [3:0] row; // opcode high nibble
    logic [3:0] lo; // opcode low nibble
    logic rmw_legal; // low nibble names an rmw op
    logic [15:0] next_ea; // effective address
    logic tested_bit; // bit picked by bit-branch
    logic [15:0] bb_dest; // bit-branch destination
    logic [15:0] rel_dest; // relative destination

    assign row = opcode_in[7:4];
    assign lo = opcode_in[3:0];
    assign tested_bit = mem_byte_in[opcode_in[3:1]];
    // next pc plus signed third byte
    assign bb_dest = branch_dest(pc_next_in, operand2_in);
    assign rel_dest = branch_dest(pc_next_in, operand1_in);

    // legal read-modify-write nibbles
    always_comb begin
        unique case (lo)
            4'h1, 4'h2, 4'h5, 4'hB, 4'hE: rmw_legal = 1'b0;
            default: rmw_legal = 1'b1;
        endcase
    end

    // class and mode from the opcode row
    always_comb begin
        next_decode = '{cls: CICD_CLS_ILLEGAL, mode: CICD_MODE_INH,
                        sel: lo, use_idx: 1'b0, push_pc: 1'b0,
                        pop_pc: 1'b0, sp_reset: 1'b0};
        unique case (row)
            // bit branch is direct plus relative
            `CICD_ROW_BITBR: begin
                next_decode.cls = CICD_CLS_BITMAN;
                next_decode.mode = CICD_MODE_REL;
            end
            // set/clear exist only in direct form
            `CICD_ROW_BITMAN: begin
                next_decode.cls = CICD_CLS_BITMAN;
                next_decode.mode = CICD_MODE_DIR;
            end
            `CICD_ROW_BRANCH: begin
                next_decode.cls = CICD_CLS_JUMP;
                next_decode.mode = CICD_MODE_REL;
            end
            `CICD_ROW_RMW_DIR, `CICD_ROW_RMW_A, `CICD_ROW_RMW_X,
            `CICD_ROW_RMW_IX1, `CICD_ROW_RMW_IX: begin
                if (rmw_legal) begin
                    next_decode.cls = CICD_CLS_RMW;
                end
                if (row == `CICD_ROW_RMW_DIR) begin
                    next_decode.mode = CICD_MODE_DIR;
                end else if (row == `CICD_ROW_RMW_IX1) begin
                    next_decode.mode = CICD_MODE_IX1;
                end else if (row == `CICD_ROW_RMW_IX) begin
                    next_decode.mode = CICD_MODE_IX;
                end
                next_decode.use_idx = (row == `CICD_ROW_RMW_X);
                // multiply sits in the accumulator row
                if (opcode_in == `CICD_OP_UMULT) begin
                    next_decode.cls = CICD_CLS_REGMEM;
                end
            end
            `CICD_ROW_CTL_A, `CICD_ROW_CTL_B: begin
                unique case (opcode_in)
                    `CICD_OP_TRAP_RET, `CICD_OP_RTS, `CICD_OP_TRAP,
                    `CICD_OP_STOP, `CICD_OP_WAIT, `CICD_OP_A2X,
                    `CICD_OP_CLC, `CICD_OP_SEC, `CICD_OP_CLI,
                    `CICD_OP_SEI, `CICD_OP_SP_INIT, `CICD_OP_NOP,
                    `CICD_OP_X2A: next_decode.cls = CICD_CLS_CONTROL;
                    default: next_decode.cls = CICD_CLS_ILLEGAL;
                endcase
                next_decode.pop_pc = (opcode_in == `CICD_OP_TRAP_RET) ||
                                     (opcode_in == `CICD_OP_RTS);
                next_decode.push_pc = (opcode_in == `CICD_OP_TRAP);
                next_decode.sp_reset = (opcode_in == `CICD_OP_SP_INIT);
            end
            // operation named by the low nibble
            default: begin
                next_decode.cls = CICD_CLS_REGMEM;
                next_decode.use_idx = (lo == 4'h3) || (lo >= 4'hE);
                if (row == `CICD_ROW_IMM) begin
                    next_decode.mode = CICD_MODE_IMM;
                end else if (row == `CICD_ROW_DIR) begin
                    next_decode.mode = CICD_MODE_DIR;
                end else if (row == `CICD_ROW_EXT) begin
                    next_decode.mode = CICD_MODE_EXT;
                end else if (row == `CICD_ROW_IX2) begin
                    next_decode.mode = CICD_MODE_IX2;
                end else if (row == `CICD_ROW_IX1) begin
                    next_decode.mode = CICD_MODE_IX1;
                end else begin
                    next_decode.mode = CICD_MODE_IX;
                end
                if (lo == `CICD_RM_JUMP || lo == `CICD_RM_JUMP_SUB) begin
                    next_decode.cls = CICD_CLS_JUMP;
                    next_decode.use_idx = 1'b0;
                    next_decode.push_pc = (lo == `CICD_RM_JUMP_SUB);
                end
                if (opcode_in == `CICD_OP_BR_SUB) begin
                    next_decode.cls = CICD_CLS_JUMP;
                    next_decode.mode = CICD_MODE_REL;
                    next_decode.push_pc = 1'b1;
                end
                // store and jump have no immediate form
                if (row == `CICD_ROW_IMM && (lo == 4'h7 ||
                    lo == 4'hC || lo == 4'hF)) begin
                    next_decode.cls = CICD_CLS_ILLEGAL;
                end
            end
        endcase
    end

    // effective address by mode
    always_comb begin
        unique case (next_decode.mode)
            // direct page high byte is zero
            CICD_MODE_DIR, CICD_MODE_REL:
                next_ea = {`CICD_DIRECT_PAGE, operand1_in};
            CICD_MODE_EXT: next_ea = {operand1_in, operand2_in};
            CICD_MODE_IX: next_ea = {`CICD_DIRECT_PAGE, idx_in};
            CICD_MODE_IX1: next_ea = 16'({8'h00, operand1_in} +
                                         {8'h00, idx_in});
            CICD_MODE_IX2: next_ea = 16'({operand1_in, operand2_in} +
                                         {8'h00, idx_in});
            default: next_ea = 16'h0000;
        endcase
    end

    // execution results, combinational
    logic [7:0] rmw_src; // value read by rmw
    logic [8:0] rmw_res; // {carry, result}
    logic [15:0] product; // multiply result
    logic br_ok; // relative condition true
    logic [7:0] bit_res; // byte after set/clear

    assign rmw_src = (row == `CICD_ROW_RMW_A) ? acc_in :
                     (row == `CICD_ROW_RMW_X) ? idx_in : mem_byte_in;
    assign rmw_res = rmw_calc(lo, rmw_src, ccr_in.c);
    assign product = {8'h00, acc_in} * {8'h00, idx_in};
    // pin level joins the condition set
    assign br_ok = branch_cond(lo, ccr_in, irq_pin_in);

    // set or clear the opcode's bit, even codes set
    always_comb begin
        bit_res = mem_byte_in;
        bit_res[opcode_in[3:1]] = ~opcode_in[0];
    end

    // completion strobe and decode register
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            done_out <= 1'b0;
            decode_out <= '{cls: CICD_CLS_ILLEGAL, mode: CICD_MODE_INH,
                            sel: 4'h0, use_idx: 1'b0, push_pc: 1'b0,
                            pop_pc: 1'b0, sp_reset: 1'b0};
            ea_out <= `CICD_PC_RESET;
        end else begin
            done_out <= op_valid_in;
            if (op_valid_in) begin
                decode_out <= next_decode;
                ea_out <= next_ea;
            end
        end
    end

    // program flow outputs
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            branch_taken_out <= 1'b0;
            pc_target_out <= `CICD_PC_RESET;
        end else if (op_valid_in) begin
            branch_taken_out <= 1'b0;
            pc_target_out <= pc_next_in;
            if (row == `CICD_ROW_BITBR) begin
                if (tested_bit == ~opcode_in[0]) begin
                    branch_taken_out <= 1'b1;
                    pc_target_out <= bb_dest;
                end
            end else if (row == `CICD_ROW_BRANCH ||
                         opcode_in == `CICD_OP_BR_SUB) begin
                if (br_ok || opcode_in == `CICD_OP_BR_SUB) begin
                    branch_taken_out <= 1'b1;
                    pc_target_out <= rel_dest;
                end
            end else if (next_decode.cls == CICD_CLS_JUMP) begin
                // jump target is the effective address
                branch_taken_out <= 1'b1;
                pc_target_out <= next_ea;
            end
        end
    end

    // write-back path
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            wb_en_out <= 1'b0;
            wb_target_out <= CICD_WB_NONE;
            wb_data_out <= `CICD_BYTE_RESET;
        end else if (op_valid_in) begin
            wb_en_out <= 1'b0;
            wb_target_out <= CICD_WB_NONE;
            wb_data_out <= rmw_res[7:0];
            if (row == `CICD_ROW_BITMAN) begin
                wb_en_out <= 1'b1;
                wb_target_out <= CICD_WB_MEM;
                wb_data_out <= bit_res;
            end else if (next_decode.cls == CICD_CLS_RMW) begin
                // write back to the place read
                wb_en_out <= (lo != `CICD_RMW_TEST);
                wb_target_out <= (lo == `CICD_RMW_TEST) ? CICD_WB_NONE :
                                 (row == `CICD_ROW_RMW_A) ? CICD_WB_ACC :
                                 (row == `CICD_ROW_RMW_X) ? CICD_WB_IDX :
                                 CICD_WB_MEM;
            end
        end
    end

    // register results and condition codes
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            acc_out <= `CICD_BYTE_RESET;
            idx_out <= `CICD_BYTE_RESET;
            ccr_out <= '{h: 1'b0, i: 1'b1, n: 1'b0, z: 1'b0, c: 1'b0};
        end else if (op_valid_in) begin
            acc_out <= acc_in;
            idx_out <= idx_in;
            ccr_out <= ccr_in;
            // tested bit into carry, taken or not
            if (row == `CICD_ROW_BITBR) begin
                ccr_out.c <= tested_bit;
            end else if (next_decode.cls == CICD_CLS_RMW) begin
                // flags follow the test result too
                ccr_out.c <= rmw_res[8];
                ccr_out.n <= rmw_res[7];
                ccr_out.z <= (rmw_res[7:0] == 8'h00);
                if (row == `CICD_ROW_RMW_A) begin
                    acc_out <= rmw_res[7:0];
                end
                if (row == `CICD_ROW_RMW_X) begin
                    idx_out <= rmw_res[7:0];
                end
            end
            unique case (opcode_in)
                // high byte to index, low to acc
                `CICD_OP_UMULT: begin
                    idx_out <= product[15:8];
                    acc_out <= product[7:0];
                    ccr_out.h <= 1'b0;
                    ccr_out.c <= 1'b0;
                end
                `CICD_OP_A2X: idx_out <= acc_in;
                `CICD_OP_X2A: acc_out <= idx_in;
                `CICD_OP_CLC: ccr_out.c <= 1'b0;
                `CICD_OP_SEC: ccr_out.c <= 1'b1;
                `CICD_OP_CLI: ccr_out.i <= 1'b0;
                `CICD_OP_SEI, `CICD_OP_TRAP: ccr_out.i <= 1'b1;
                `CICD_OP_STOP, `CICD_OP_WAIT: ccr_out.i <= 1'b0;
                default: ccr_out.i <= ccr_in.i;
            endcase
        end
    end

    // low-power requests, one-cycle pulses
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            stop_req_out <= 1'b0;
            wait_req_out <= 1'b0;
        end else begin
            stop_req_out <= op_valid_in && (opcode_in == `CICD_OP_STOP);
            wait_req_out <= op_valid_in && (opcode_in == `CICD_OP_WAIT);
        end
    end

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!reset_n_in);

    a_bitbr_carry_copy: assert property (
        op_valid_in && row == `CICD_ROW_BITBR |=>
        ccr_out.c == $past(tested_bit))
        else $error("bit branch carry differs from tested bit");

    a_bitbr_taken_dest: assert property (
        op_valid_in && row == `CICD_ROW_BITBR &&
        tested_bit == ~opcode_in[0] |=>
        branch_taken_out && pc_target_out == $past(bb_dest))
        else $error("bit branch destination wrong");

    a_test_no_write: assert property (
        op_valid_in && next_decode.cls == CICD_CLS_RMW &&
        lo == `CICD_RMW_TEST |=> !wb_en_out && done_out)
        else $error("test instruction wrote back");

    a_rmw_write_back: assert property (
        op_valid_in && row == `CICD_ROW_RMW_DIR && rmw_legal &&
        lo != `CICD_RMW_TEST |=>
        wb_en_out && wb_target_out == CICD_WB_MEM && ea_out[15:8] == 8'h00)
        else $error("rmw write-back missing");

    a_bitman_direct_only: assert property (
        op_valid_in && row == `CICD_ROW_BITMAN |=>
        decode_out.mode == CICD_MODE_DIR && ea_out[15:8] == 8'h00 &&
        ea_out[7:0] == $past(operand1_in))
        else $error("bit set/clear not direct");

    a_mul_split: assert property (
        op_valid_in && opcode_in == `CICD_OP_UMULT |=>
        {idx_out, acc_out} == $past(acc_in) * $past(idx_in))
        else $error("multiply product misplaced");

    a_cond_not_taken: assert property (
        op_valid_in && row == `CICD_ROW_BRANCH && !br_ok |=>
        !branch_taken_out && pc_target_out == $past(pc_next_in))
        else $error("branch taken with false condition");

    a_pin_branch_high: assert property (
        op_valid_in && row == `CICD_ROW_BRANCH && lo == 4'hF |=>
        branch_taken_out == $past(irq_pin_in))
        else $error("pin-high branch wrong");

    a_stop_pulse: assert property (
        op_valid_in && opcode_in == `CICD_OP_STOP |=>
        stop_req_out && !ccr_out.i ##1 !stop_req_out)
        else $error("stop request wrong");

    a_wait_unmask: assert property (
        op_valid_in && opcode_in == `CICD_OP_WAIT |=>
        wait_req_out && !ccr_out.i)
        else $error("wait request wrong");

endmodule : cicd_core

// [tb/cicd_mem_model.sv]
`timescale 1ns/1ps
// direct page memory: every location reads back a fixed pattern
module cicd_mem_model (
    input wire logic [7:0] addr_in,
    output logic [7:0] data_out
);
    // readable only
    // no write-only places, so every preliminary read is meaningful
    assign data_out = addr_in ^ 8'h5A;
endmodule : cicd_mem_model

// [tb/cicd_core_tb_top.sv]
`timescale 1ns/1ps
module cicd_core_tb_top;
    import cicd_pkg::*;
    logic core_clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic op_valid_in = 1'b0;
    logic [7:0] opcode_in = 8'h00;
    logic [7:0] operand1_in = 8'h00;
    logic [7:0] operand2_in = 8'h00;
    logic [15:0] pc_next_in = 16'h0000;
    logic [7:0] acc_in = 8'h00;
    logic [7:0] idx_in = 8'h00;
    logic [7:0] mem_byte_in;
    cicd_ccr_t ccr_in = 5'h08;
    logic irq_pin_in = 1'b0;
    cicd_decode_t decode_out;
    logic done_out, branch_taken_out, wb_en_out, stop_req_out, wait_req_out;
    logic [15:0] pc_target_out, ea_out;
    cicd_wb_t wb_target_out;
    logic [7:0] wb_data_out, acc_out, idx_out;
    cicd_ccr_t ccr_out;
    int num_errors = 0;
    int checks_done = 0;
    int cycles = 0;
    cicd_core cicd_core_inst (.core_clk_in, .reset_n_in, .op_valid_in,
        .opcode_in, .operand1_in, .operand2_in, .pc_next_in, .acc_in,
        .idx_in, .mem_byte_in, .ccr_in, .irq_pin_in, .decode_out,
        .done_out, .branch_taken_out, .pc_target_out, .ea_out, .wb_en_out,
        .wb_target_out, .wb_data_out, .acc_out, .idx_out, .ccr_out,
        .stop_req_out, .wait_req_out);
    // memory answers at the direct address in the second byte
    cicd_mem_model cicd_mem_model_inst (.addr_in(operand1_in),
        .data_out(mem_byte_in));
    // free-running clock and hang guard
    always #5 core_clk_in = ~core_clk_in;
    always @(posedge core_clk_in) begin
        cycles++;
        if (cycles == 500) begin
            num_errors++;
            tally_and_finish();
        end
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // present one instruction for one cycle, results settle by next fall
    task automatic run(input logic [7:0] op, o1, o2, input logic [15:0] pn);
        @(negedge core_clk_in);
        op_valid_in = 1'b1;
        opcode_in = op;
        operand1_in = o1;
        operand2_in = o2;
        pc_next_in = pn;
        @(negedge core_clk_in);
        op_valid_in = 1'b0;
        chk(done_out, 16'h0001);
    endtask : run
    task automatic t_bit_branch();
        run(8'h05, 8'h10, 8'hFE, 16'h0100);
        chk(branch_taken_out, 16'h0001);
        chk(pc_target_out, 16'h00FE);
        chk(ccr_out.c, 16'h0000);
        chk(ea_out, 16'h0010);
        run(8'h04, 8'h10, 8'hFE, 16'h0100);
        chk(branch_taken_out, 16'h0000);
        chk(pc_target_out, 16'h0100);
        $display("test bit_branch done");
    endtask : t_bit_branch
    task automatic t_rmw();
        run(8'h3C, 8'h10, 8'h00, 16'h0102);
        chk(wb_en_out, 16'h0001);
        chk(wb_target_out, CICD_WB_MEM);
        chk(wb_data_out, 16'h004B);
        run(8'h3D, 8'h10, 8'h00, 16'h0104);
        chk(wb_en_out, 16'h0000);
        run(8'h10, 8'h10, 8'h00, 16'h0106);
        chk(wb_data_out, 16'h004B);
        $display("test rmw done");
    endtask : t_rmw
    task automatic t_mul_pin_wrap();
        acc_in = 8'hFF;
        idx_in = 8'hFF;
        irq_pin_in = 1'b1;
        run(8'h42, 8'h00, 8'h00, 16'h0201);
        chk(idx_out, 16'h00FE);
        chk(acc_out, 16'h0001);
        run(8'h2F, 8'h04, 8'h00, 16'h0300);
        chk(pc_target_out, 16'h0304);
        run(8'h2E, 8'h04, 8'h00, 16'h0300);
        chk(branch_taken_out, 16'h0000);
        run(8'h20, 8'h01, 8'h00, 16'hFFFF);
        chk(pc_target_out, 16'h0000);
        run(8'hCC, 8'h12, 8'h34, 16'h0500);
        chk(branch_taken_out, 16'h0001);
        chk(pc_target_out, 16'h1234);
        run(8'hAB, 8'h00, 8'h00, 16'h0502);
        chk(decode_out.cls, CICD_CLS_REGMEM);
        chk(decode_out.sel, 16'h000B);
        run(8'h81, 8'h00, 8'h00, 16'h0503);
        chk(decode_out.pop_pc, 16'h0001);
        $display("test mul_pin_wrap done");
    endtask : t_mul_pin_wrap
    task automatic t_low_power();
        run(8'h8E, 8'h00, 8'h00, 16'h0400);
        chk(stop_req_out, 16'h0001);
        chk(ccr_out.i, 16'h0000);
        run(8'h8F, 8'h00, 8'h00, 16'h0401);
        chk(wait_req_out, 16'h0001);
        $display("test low_power done");
    endtask : t_low_power
    task automatic tally_and_finish();
        $display("checks=%0d errors=%0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : tally_and_finish
    // reset, reset values, then the scenarios in turn
    initial begin
        repeat (5) @(negedge core_clk_in);
        chk(decode_out.cls, CICD_CLS_ILLEGAL);
        chk(ccr_out.i, 16'h0001);
        reset_n_in = 1'b1;
        t_bit_branch();
        t_rmw();
        t_mul_pin_wrap();
        t_low_power();
        tally_and_finish();
    end
endmodule : cicd_core_tb_top
